// ==== pdcr_defs.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the dma command block
// Assumes: 100 MHz clock
// Notes:   definitions only
`ifndef PDCR_DEFS_SVH
`define PDCR_DEFS_SVH

// second window (bar 1)
`define PDCR_OFS_SCRATCH   16'h0000
`define PDCR_OFS_LENGTH    16'h8008
`define PDCR_OFS_DIRECTION 16'h800c
`define PDCR_OFS_CYCLES    16'h8014
`define PDCR_OFS_DONE      16'h8018
`define PDCR_OFS_HOST_BASE 16'h8028
// first window (bar 0)
`define PDCR_OFS_SWITCH    16'h0090
`define PDCR_OFS_LAMP      16'h00a0

`define PDCR_SWITCH_LSB    8
`define PDCR_SWITCH_MSB    11
`define PDCR_LAMP_MSB      7

`define PDCR_DIR_HOST_TO_DDR 32'h11aa1111
`define PDCR_DIR_DDR_TO_HOST 32'h11aa2222
`define PDCR_DIR_SRAM_TO_DDR 32'h11aa3333
`define PDCR_DIR_DDR_TO_SRAM 32'h11aa4444

`define PDCR_RESET_WORD    32'h0000_0000
`define PDCR_RESET_LAMP    8'h00

// transfer length limits in bytes
`define PDCR_HOST_MIN_LEN  32'h0001_0000
`define PDCR_HOST_MAX_LEN  32'h0010_0000
`define PDCR_HOST_STEP_MSB 15
`define PDCR_SRAM_MIN_LEN  32'h0000_4000
`define PDCR_SRAM_MAX_LEN  32'h0000_8000
`define PDCR_BEAT_BYTES    32'h0000_0004

`define PDCR_FIFO_DEPTH    8
`define PDCR_CLK_MHZ       100
`define PDCR_SAMPLE_US     1000
`define PDCR_SAMPLE_CYCLES (`PDCR_SAMPLE_US * `PDCR_CLK_MHZ)

`endif

// ==== pdcr_pkg.sv ====
// Purpose: types shared by the dma command block
// Assumes: nothing
// Notes:   constants live in pdcr_defs.svh
package pdcr_pkg;
  typedef enum logic [1:0] {
    pdcr_tgt_host = 2'b00,
    pdcr_tgt_ddr  = 2'b01,
    pdcr_tgt_sram = 2'b10
  } pdcr_target_type;

  typedef enum logic [1:0] {
    pdcr_idle = 2'b00,
    pdcr_run  = 2'b01,
    pdcr_wait = 2'b11
  } pdcr_state_type;
endpackage : pdcr_pkg

// ==== pdcr_fifo.sv ====
// Purpose: small word fifo between the read and write sides of the engine
// Assumes: single clock, synchronous reset
// Notes:   out_data is the head entry held in flops
`timescale 1ns/10ps
module pdcr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill < (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill   = fill;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_fill = fill + 1'b1;
    end else if (pop && !push) begin
      next_fill = fill - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  // storage needs no reset; out_valid guards it
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule : pdcr_fifo

// ==== pdcr_button.sv ====
// Purpose: push-button press detector and interrupt request
// Assumes: button level synchronous to clk, active high when pressed
// Notes:   sampled once per tick so contact bounce gives one press
`timescale 1ns/10ps
module pdcr_button #(
  parameter int SAMPLE_CYCLES = 100000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // board and host control
  input  wire logic button,
  input  wire logic irq_enable,
  input  wire logic irq_clear,
  // interrupt
  output logic      irq_pending,
  output logic      irq_send
);
  logic [31:0] tick_count;
  logic [31:0] next_tick_count;
  logic        tick;
  logic        sampled;
  logic        next_sampled;
  logic        next_irq_pending;
  logic        next_irq_send;
  logic        press;

  assign tick  = (tick_count == 32'(SAMPLE_CYCLES - 1));
  assign press = tick && button && !sampled;

  always_comb begin
    next_tick_count  = tick ? 32'h0000_0000 : tick_count + 32'h0000_0001;
    next_sampled     = tick ? button : sampled;
    next_irq_send    = press && irq_enable;
    next_irq_pending = irq_pending;
    if (irq_clear || !irq_enable) begin
      next_irq_pending = 1'b0;
    end
    // a press in the clearing cycle still counts
    if (press && irq_enable) begin
      next_irq_pending = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tick_count  <= 32'h0000_0000;
      sampled     <= 1'b0;
      irq_pending <= 1'b0;
      irq_send    <= 1'b0;
    end else begin
      tick_count  <= next_tick_count;
      sampled     <= next_sampled;
      irq_pending <= next_irq_pending;
      irq_send    <= next_irq_send;
    end
  end
endmodule : pdcr_button

// ==== pdcr_dma.sv ====
// Purpose: register-controlled dma command block behind the pcie endpoint
// Assumes: register port and beat ports synchronous to clk, 100 MHz
// Notes:   one read beat in flight at a time; every beat is 4 bytes
`timescale 1ns/10ps
`include "pdcr_defs.svh"

// Summary of operation
// - host writes its buffer base; host-side beats use it as address.
// - host writes transfer length in bytes; engine moves that many bytes.
// - direction codes select host-to-ddr and ddr-to-host transfers.
// - direction codes select sram-to-ddr and ddr-to-sram transfers.
// - clock cycles of each transfer are counted and readable afterwards.
// - completion flag reads 1 when done, 0 while incomplete.
// - 32-bit scratch word at offset zero of second window reads back.
// - host transfers take 64 KB to 1 MB in 64 KB steps.
// - sram transfers take 16 KB to 32 KB.
// - every generated pcie transaction carries exactly 4 bytes.
// - each packet is one single 32-bit beat, never a burst.
// - 8-bit lamp control register drives the board lamps.
// - dip switch positions read in bits 11 to 8 at 0x90.
// - enabled push-button press sends one interrupt per press.
// - host clears pending interrupts and disables further ones.
module pdcr_dma
  import pdcr_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `PDCR_SAMPLE_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port from the endpoint
  input  wire logic        reg_bar,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rdata_valid,
  // read beat requests
  output logic             rd_req_valid,
  input  wire logic        rd_req_ready,
  output pdcr_target_type  rd_req_target,
  output logic      [31:0] rd_req_addr,
  input  wire logic        rd_data_valid,
  input  wire logic [31:0] rd_data,
  // write beat requests
  output logic             wr_req_valid,
  input  wire logic        wr_req_ready,
  output pdcr_target_type  wr_req_target,
  output logic      [31:0] wr_req_addr,
  output logic      [31:0] wr_req_data,
  // board
  output logic      [7:0]  lamp,
  input  wire logic [3:0]  dip_switch,
  input  wire logic        button,
  // interrupt control and request
  input  wire logic        irq_enable,
  input  wire logic        irq_clear,
  output logic             irq_pending,
  output logic             irq_send
);
  // register file
  logic [31:0]     scratch_word;
  logic [7:0]      lamp_control;
  logic [31:0]     transfer_length;
  logic [31:0]     transfer_direction;
  logic [31:0]     transfer_cycle_count;
  logic            transfer_done_flag;
  logic [31:0]     host_buffer_base;
  logic [31:0]     next_scratch_word;
  logic [7:0]      next_lamp_control;
  logic [31:0]     next_transfer_length;
  logic [31:0]     next_transfer_direction;
  logic [31:0]     next_host_buffer_base;
  logic [31:0]     next_reg_rdata;
  logic            bar0_hit;
  logic            bar1_hit;
  // engine
  pdcr_state_type  state;
  pdcr_state_type  next_state;
  pdcr_target_type src;
  pdcr_target_type dst;
  pdcr_target_type next_src;
  pdcr_target_type next_dst;
  logic [31:0]     beats;
  logic [31:0]     next_beats;
  logic [31:0]     reads_issued;
  logic [31:0]     next_reads_issued;
  logic [31:0]     writes_done;
  logic [31:0]     next_writes_done;
  logic [31:0]     next_cycle_count;
  logic            next_done_flag;
  logic            start;
  logic            dir_known;
  logic            len_ok;
  pdcr_target_type code_src;
  pdcr_target_type code_dst;
  // fifo ties
  logic            fifo_in_ready;
  logic            fifo_out_valid;
  logic [31:0]     fifo_out_data;
  logic            wr_fire;
  logic            rd_fire;

  assign bar0_hit = !reg_bar;
  assign bar1_hit = reg_bar;

  // decode a direction code and check the length it needs
  always_comb begin
    dir_known = 1'b1;
    code_src  = pdcr_tgt_ddr;
    code_dst  = pdcr_tgt_ddr;
    len_ok    = 1'b0;
    unique case (reg_wdata)
      `PDCR_DIR_HOST_TO_DDR: begin
        code_src = pdcr_tgt_host;
      end
      `PDCR_DIR_DDR_TO_HOST: begin
        code_dst = pdcr_tgt_host;
      end
      `PDCR_DIR_SRAM_TO_DDR: begin
        code_src = pdcr_tgt_sram;
      end
      `PDCR_DIR_DDR_TO_SRAM: begin
        code_dst = pdcr_tgt_sram;
      end
      default: begin
        dir_known = 1'b0;
      end
    endcase
    if (code_src == pdcr_tgt_host || code_dst == pdcr_tgt_host) begin
      len_ok = (transfer_length >= `PDCR_HOST_MIN_LEN) &&
               (transfer_length <= `PDCR_HOST_MAX_LEN) &&
               (transfer_length[`PDCR_HOST_STEP_MSB:0] == '0);
    end else begin
      len_ok = (transfer_length >= `PDCR_SRAM_MIN_LEN) &&
               (transfer_length <= `PDCR_SRAM_MAX_LEN) &&
               (transfer_length[1:0] == 2'b00);
    end
  end

  // a new transfer only from idle, never over a running one
  assign start = reg_write && bar1_hit && (reg_addr == `PDCR_OFS_DIRECTION) &&
                 dir_known && len_ok && (state == pdcr_idle);

  // register writes and reads
  always_comb begin
    next_scratch_word       = scratch_word;
    next_lamp_control       = lamp_control;
    next_transfer_length    = transfer_length;
    next_transfer_direction = transfer_direction;
    next_host_buffer_base   = host_buffer_base;
    next_reg_rdata          = `PDCR_RESET_WORD;
    if (reg_write && bar1_hit) begin
      unique case (reg_addr)
        `PDCR_OFS_SCRATCH:   next_scratch_word = reg_wdata;
        `PDCR_OFS_LENGTH:    next_transfer_length = reg_wdata;
        `PDCR_OFS_DIRECTION: next_transfer_direction = reg_wdata;
        `PDCR_OFS_HOST_BASE: next_host_buffer_base = reg_wdata;
        default: ;
      endcase
    end
    if (reg_write && bar0_hit && reg_addr == `PDCR_OFS_LAMP) begin
      next_lamp_control = reg_wdata[`PDCR_LAMP_MSB:0];
    end
    if (reg_read && bar1_hit) begin
      unique case (reg_addr)
        `PDCR_OFS_SCRATCH:   next_reg_rdata = scratch_word;
        `PDCR_OFS_LENGTH:    next_reg_rdata = transfer_length;
        `PDCR_OFS_DIRECTION: next_reg_rdata = transfer_direction;
        `PDCR_OFS_CYCLES:    next_reg_rdata = transfer_cycle_count;
        `PDCR_OFS_DONE:      next_reg_rdata = {31'h0, transfer_done_flag};
        `PDCR_OFS_HOST_BASE: next_reg_rdata = host_buffer_base;
        default: ;
      endcase
    end
    if (reg_read && bar0_hit) begin
      if (reg_addr == `PDCR_OFS_LAMP) begin
        next_reg_rdata = {24'h0, lamp_control};
      end else if (reg_addr == `PDCR_OFS_SWITCH) begin
        next_reg_rdata[`PDCR_SWITCH_MSB:`PDCR_SWITCH_LSB] = dip_switch;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      scratch_word       <= `PDCR_RESET_WORD;
      lamp_control       <= `PDCR_RESET_LAMP;
      transfer_length    <= `PDCR_RESET_WORD;
      transfer_direction <= `PDCR_RESET_WORD;
      host_buffer_base   <= `PDCR_RESET_WORD;
      reg_rdata          <= `PDCR_RESET_WORD;
      reg_rdata_valid    <= 1'b0;
    end else begin
      scratch_word       <= next_scratch_word;
      lamp_control       <= next_lamp_control;
      transfer_length    <= next_transfer_length;
      transfer_direction <= next_transfer_direction;
      host_buffer_base   <= next_host_buffer_base;
      reg_rdata          <= next_reg_rdata;
      reg_rdata_valid    <= reg_read;
    end
  end

  assign lamp = lamp_control;

  // read side: one single beat outstanding; issued only while the fifo has a slot,
  // so the returning word always fits
  assign rd_req_valid  = (state == pdcr_run) && (reads_issued != beats) &&
                         fifo_in_ready;
  assign rd_req_target = src;
  assign rd_req_addr   = ((src == pdcr_tgt_host) ? host_buffer_base : 32'h0) +
                         (reads_issued << 2);
  assign rd_fire       = rd_req_valid && rd_req_ready;

  // write side drains the fifo one 4-byte beat at a time
  assign wr_req_valid  = (state != pdcr_idle) && fifo_out_valid;
  assign wr_req_target = dst;
  assign wr_req_addr   = ((dst == pdcr_tgt_host) ? host_buffer_base : 32'h0) +
                         (writes_done << 2);
  assign wr_req_data   = fifo_out_data;
  assign wr_fire       = wr_req_valid && wr_req_ready;

  always_comb begin
    next_state        = state;
    next_src          = src;
    next_dst          = dst;
    next_beats        = beats;
    next_reads_issued = reads_issued;
    next_writes_done  = writes_done;
    next_cycle_count  = transfer_cycle_count;
    next_done_flag    = transfer_done_flag;
    unique case (state)
      pdcr_idle: begin
        if (start) begin
          next_state        = pdcr_run;
          next_src          = code_src;
          next_dst          = code_dst;
          next_beats        = transfer_length >> 2;
          next_reads_issued = 32'h0;
          next_writes_done  = 32'h0;
          next_cycle_count  = 32'h0;
          next_done_flag    = 1'b0;
        end
      end
      pdcr_run: begin
        next_cycle_count = transfer_cycle_count + 32'h1;
        if (rd_fire) begin
          next_state        = pdcr_wait;
          next_reads_issued = reads_issued + 32'h1;
        end
      end
      pdcr_wait: begin
        next_cycle_count = transfer_cycle_count + 32'h1;
        if (rd_data_valid) begin
          next_state = pdcr_run;
        end
      end
      default: next_state = pdcr_idle;
    endcase
    if (wr_fire) begin
      next_writes_done = writes_done + 32'h1;
      if (writes_done + 32'h1 == beats) begin
        next_state     = pdcr_idle;
        next_done_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state                <= pdcr_idle;
      src                  <= pdcr_tgt_ddr;
      dst                  <= pdcr_tgt_ddr;
      beats                <= 32'h0;
      reads_issued         <= 32'h0;
      writes_done          <= 32'h0;
      transfer_cycle_count <= 32'h0;
      transfer_done_flag   <= 1'b0;
    end else begin
      state                <= next_state;
      src                  <= next_src;
      dst                  <= next_dst;
      beats                <= next_beats;
      reads_issued         <= next_reads_issued;
      writes_done          <= next_writes_done;
      transfer_cycle_count <= next_cycle_count;
      transfer_done_flag   <= next_done_flag;
    end
  end

  pdcr_fifo #(
    .WIDTH (32),
    .DEPTH (`PDCR_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (rd_data_valid && state == pdcr_wait),
    .in_ready  (fifo_in_ready),
    .in_data   (rd_data),
    .out_valid (fifo_out_valid),
    .out_ready (wr_req_ready && state != pdcr_idle),
    .out_data  (fifo_out_data)
  );

  pdcr_button #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES)
  ) u_button (
    .clk         (clk),
    .reset       (reset),
    .button      (button),
    .irq_enable  (irq_enable),
    .irq_clear   (irq_clear),
    .irq_pending (irq_pending),
    .irq_send    (irq_send)
  );
endmodule : pdcr_dma

// ==== pdcr_properties.sv ====
// Purpose: port checker for pdcr_dma
// Assumes: one clock, synchronous reset
// Notes:   bound into every pdcr_dma instance
`timescale 1ns/10ps
`include "pdcr_defs.svh"
module pdcr_properties
  import pdcr_pkg::*;
(
  // clock and reset
  input wire logic            clk,
  input wire logic            reset,
  // register port
  input wire logic            reg_bar,
  input wire logic [15:0]     reg_addr,
  input wire logic            reg_write,
  input wire logic            reg_read,
  input wire logic [31:0]     reg_wdata,
  input wire logic [31:0]     reg_rdata,
  input wire logic            reg_rdata_valid,
  // beat ports
  input wire logic            rd_req_valid,
  input wire logic            rd_req_ready,
  input wire pdcr_target_type rd_req_target,
  input wire logic [31:0]     rd_req_addr,
  input wire logic            wr_req_valid,
  input wire logic            wr_req_ready,
  input wire logic [31:0]     wr_req_addr,
  input wire logic [31:0]     wr_req_data,
  // board and interrupt
  input wire logic [7:0]      lamp,
  input wire logic [3:0]      dip_switch,
  input wire logic            irq_enable,
  input wire logic            irq_pending,
  input wire logic            irq_send
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  read_answer_a: assert property (reg_read |=> reg_rdata_valid)
    else $error("read not answered");
  answer_cause_a: assert property (reg_rdata_valid |-> $past(reg_read))
    else $error("answer without read");
  lamp_drive_a: assert property (reg_write && !reg_bar && reg_addr == `PDCR_OFS_LAMP
    |=> ##1 lamp == $past(reg_wdata[7:0], 2)) else $error("lamp not driven");
  switch_read_a: assert property (reg_read && !reg_bar && reg_addr == `PDCR_OFS_SWITCH
    |=> reg_rdata[11:8] == $past(dip_switch)) else $error("switch bits wrong");
  read_hold_a: assert property (rd_req_valid && !rd_req_ready |=> rd_req_valid
    && $stable(rd_req_addr) && $stable(rd_req_target)) else $error("read request dropped");
  write_hold_a: assert property (wr_req_valid && !wr_req_ready |=> wr_req_valid
    && $stable(wr_req_addr) && $stable(wr_req_data)) else $error("write request dropped");
  beat_align_a: assert property ((rd_req_valid || wr_req_valid) |->
    rd_req_addr[1:0] == 2'h0 && wr_req_addr[1:0] == 2'h0) else $error("beat not a word");
  irq_single_a: assert property (irq_send |=> !irq_send)
    else $error("interrupt repeated");
  irq_mark_a: assert property (irq_send |-> irq_pending)
    else $error("interrupt not pending");
  irq_gate_a: assert property (!irq_enable |=> !irq_send)
    else $error("interrupt while disabled");

  cover property (irq_send);
  cover property (wr_req_valid && !wr_req_ready);
  cover property (rd_req_valid && rd_req_target == pdcr_tgt_sram);
endmodule : pdcr_properties

bind pdcr_dma pdcr_properties u_properties (.*);

// ==== pdcr_memory_model.sv ====
// Purpose: memory side model answering read and write beats
// Assumes: beat handshakes sampled on rising clk
// Notes:   slow stalls every other cycle; checks order, address and data
`timescale 1ns/10ps
module pdcr_memory_model
  import pdcr_pkg::*;
(
  // clock and control
  input  wire logic            clk,
  input  wire logic            clear,
  input  wire logic            slow,
  input  wire logic [31:0]     host_base,
  // read beats
  input  wire logic            rd_req_valid,
  output logic                 rd_req_ready,
  input  wire pdcr_target_type rd_req_target,
  input  wire logic [31:0]     rd_req_addr,
  output logic                 rd_data_valid,
  output logic      [31:0]     rd_data,
  // write beats
  input  wire logic            wr_req_valid,
  output logic                 wr_req_ready,
  input  wire pdcr_target_type wr_req_target,
  input  wire logic [31:0]     wr_req_addr,
  input  wire logic [31:0]     wr_req_data,
  // results
  output logic      [31:0]     beats,
  output logic      [31:0]     bad
);
  logic        phase;
  logic [31:0] reads;
  logic [31:0] words[$];

  function automatic logic [31:0] base_of(input pdcr_target_type t);
    return (t == pdcr_tgt_host) ? host_base : 32'h0;
  endfunction : base_of

  assign rd_req_ready = !slow || phase;
  assign wr_req_ready = !slow || phase;

  always @(posedge clk) begin
    phase <= !phase;
    rd_data_valid <= 1'b0;
    // released bus never repeats the last word
    rd_data <= ~rd_data;
    if (clear) begin
      phase <= 1'b0;
      rd_data <= 32'h0;
      reads <= 32'h0;
      beats <= 32'h0;
      bad <= 32'h0;
      words.delete();
    end else begin
      if (wr_req_valid && wr_req_ready) begin
        beats <= beats + 32'h1;
        if (words.size() == 0 || wr_req_data !== words[0] ||
            wr_req_addr !== base_of(wr_req_target) + (beats << 2)) bad <= bad + 32'h1;
        if (words.size() != 0) void'(words.pop_front());
      end
      if (rd_req_valid && rd_req_ready) begin
        reads <= reads + 32'h1;
        if (rd_req_addr !== base_of(rd_req_target) + (reads << 2)) bad <= bad + 32'h1;
        rd_data_valid <= 1'b1;
        rd_data <= rd_req_addr ^ 32'h5a5a_c3c3;
        words.push_back(rd_req_addr ^ 32'h5a5a_c3c3);
      end
    end
  end
endmodule : pdcr_memory_model

// ==== pcie_dma_command_registers_test.sv ====
// Purpose: self-checking bench for pdcr_dma
// Assumes: 100 MHz clock, inputs driven at the falling edge
// Notes:   short button sample period keeps presses brief
`timescale 1ns/10ps
`include "pdcr_defs.svh"
module pcie_dma_command_registers_test
  import pdcr_pkg::*;
;
  logic            clk, reset, reg_bar, reg_write, reg_read, reg_rdata_valid, button;
  logic            rd_req_valid, rd_req_ready, rd_data_valid, wr_req_valid, wr_req_ready;
  logic            irq_enable, irq_clear, irq_pending, irq_send, slow, clear;
  logic [15:0]     reg_addr;
  logic [31:0]     reg_wdata, reg_rdata, rd_req_addr, rd_data, wr_req_addr, wr_req_data;
  logic [31:0]     host_base, beats, bad, word;
  logic [7:0]      lamp;
  logic [3:0]      dip_switch;
  pdcr_target_type rd_req_target, wr_req_target;
  int              mismatches, check_count;

  pdcr_dma #(.SAMPLE_CYCLES(4)) dut (.*);
  pdcr_memory_model memory (.*);

  always #5 clk = ~clk;

  task automatic check(input string name, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic reg_wr(input logic bar, input logic [15:0] addr, input logic [31:0] data);
    @(negedge clk);
    reg_bar = bar;
    reg_addr = addr;
    reg_wdata = data;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic bar, input logic [15:0] addr, output logic [31:0] data);
    @(negedge clk);
    reg_bar = bar;
    reg_addr = addr;
    reg_read = 1'b1;
    @(negedge clk);
    check("read answer", 32'h1, {31'h0, reg_rdata_valid});
    data = reg_rdata;
    reg_read = 1'b0;
  endtask : reg_rd

  function automatic logic [31:0] base_for(input pdcr_target_type t);
    return (t == pdcr_tgt_host) ? host_base : 32'h0;
  endfunction : base_for

  task automatic t_reset_values;
    logic [15:0] ofs[6] = '{16'h0000, 16'h8008, 16'h800c, 16'h8014, 16'h8018, 16'h8028};
    foreach (ofs[i]) begin
      reg_rd(1'b1, ofs[i], word);
      check("reset value", 32'h0, word);
    end
    reg_rd(1'b0, 16'h8008, word);
    check("unmapped read", 32'h0, word);
    check("lamp at reset", 32'h0, {24'h0, lamp});
  endtask : t_reset_values

  task automatic t_registers;
    reg_wr(1'b1, `PDCR_OFS_SCRATCH, 32'ha5c3_0f96);
    reg_wr(1'b1, 16'h0004, 32'hffff_ffff);
    reg_rd(1'b1, `PDCR_OFS_SCRATCH, word);
    check("scratch", 32'ha5c3_0f96, word);
    reg_wr(1'b0, `PDCR_OFS_LAMP, 32'h0000_015a);
    @(negedge clk);
    check("lamp pins", 32'h5a, {24'h0, lamp});
    reg_rd(1'b0, `PDCR_OFS_LAMP, word);
    check("lamp read", 32'h5a, word & 32'hff);
    dip_switch = 4'h9;
    reg_rd(1'b0, `PDCR_OFS_SWITCH, word);
    check("switches", 32'h9, {28'h0, word[11:8]});
  endtask : t_registers

  // abort resets the block once the first write beat shows
  task automatic t_transfer(input logic [31:0] len, dir, input pdcr_target_type src, dst,
                            input logic abort);
    int n;
    clear = 1'b1;
    @(negedge clk);
    clear = 1'b0;
    reg_wr(1'b1, `PDCR_OFS_HOST_BASE, host_base);
    reg_wr(1'b1, `PDCR_OFS_LENGTH, len);
    reg_wr(1'b1, `PDCR_OFS_DIRECTION, dir);
    for (n = 0; n < 20 && rd_req_valid !== 1'b1; n++) @(negedge clk);
    check("read target", 32'(src), 32'(rd_req_target));
    check("read address", base_for(src), rd_req_addr);
    if (abort) begin
      for (n = 0; n < 50 && wr_req_valid !== 1'b1; n++) @(negedge clk);
      check("write target", 32'(dst), 32'(wr_req_target));
      check("write address", base_for(dst), wr_req_addr);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
    end else begin
      reg_rd(1'b1, `PDCR_OFS_DONE, word);
      check("done while busy", 32'h0, {31'h0, word[0]});
      for (n = 0; n < 40000 && word[0] !== 1'b1; n++) reg_rd(1'b1, `PDCR_OFS_DONE, word);
      check("done", 32'h1, {31'h0, word[0]});
      check("beats", len >> 2, beats);
      check("beat errors", 32'h0, bad);
      reg_rd(1'b1, `PDCR_OFS_CYCLES, word);
      check("cycles", 32'h1, {31'h0, word >= (len >> 2) && word <= (len << 1)});
    end
  endtask : t_transfer

  task automatic t_refused;
    reg_wr(1'b1, `PDCR_OFS_LENGTH, 32'h0000_8000);
    reg_wr(1'b1, `PDCR_OFS_DIRECTION, `PDCR_DIR_HOST_TO_DDR);
    reg_wr(1'b1, `PDCR_OFS_LENGTH, 32'h0011_0000);
    reg_wr(1'b1, `PDCR_OFS_DIRECTION, `PDCR_DIR_DDR_TO_HOST);
    reg_wr(1'b1, `PDCR_OFS_LENGTH, 32'h0000_4000);
    reg_wr(1'b1, `PDCR_OFS_DIRECTION, 32'h11aa_5555);
    repeat (4) @(negedge clk);
    check("no beat", 32'h0, {31'h0, rd_req_valid});
    reg_rd(1'b1, `PDCR_OFS_DONE, word);
    check("done kept", 32'h1, {31'h0, word[0]});
  endtask : t_refused

  task automatic press(output int sends);
    sends = 0;
    for (int i = 0; i < 24; i++) begin
      @(negedge clk);
      button = (i < 11);
      if (irq_send === 1'b1) sends++;
    end
  endtask : press

  task automatic t_irq;
    int n;
    irq_enable = 1'b1;
    press(n);
    check("sends enabled", 32'h1, 32'(n));
    check("pending", 32'h1, {31'h0, irq_pending});
    irq_clear = 1'b1;
    @(negedge clk);
    irq_clear = 1'b0;
    @(negedge clk);
    check("cleared", 32'h0, {31'h0, irq_pending});
    irq_enable = 1'b0;
    press(n);
    check("sends disabled", 32'h0, 32'(n));
    check("still clear", 32'h0, {31'h0, irq_pending});
  endtask : t_irq

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // about 41k cycles of transfers expected; 200k cycles means a hang
  initial begin
    #2000000;
    mismatches++;
    complete_run;
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {reg_bar, reg_write, reg_read, button, irq_enable, irq_clear, slow} = '0;
    reg_addr = 16'h0;
    reg_wdata = 32'h0;
    dip_switch = 4'h0;
    host_base = 32'h1234_0000;
    clear = 1'b1;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    t_reset_values;
    t_registers;
    t_transfer(32'h0001_0000, `PDCR_DIR_HOST_TO_DDR, pdcr_tgt_host, pdcr_tgt_ddr, 1'b0);
    t_refused;
    slow = 1'b1;
    t_transfer(32'h0000_4000, `PDCR_DIR_SRAM_TO_DDR, pdcr_tgt_sram, pdcr_tgt_ddr, 1'b0);
    slow = 1'b0;
    t_transfer(32'h0010_0000, `PDCR_DIR_DDR_TO_HOST, pdcr_tgt_ddr, pdcr_tgt_host, 1'b1);
    t_transfer(32'h0000_8000, `PDCR_DIR_DDR_TO_SRAM, pdcr_tgt_ddr, pdcr_tgt_sram, 1'b1);
    t_irq;
    complete_run;
  end
endmodule : pcie_dma_command_registers_test
